// ---- rtl/autoneg_regs_consts.svh ----
`ifndef AUTONEG_REGS_CONSTS_SVH
`define AUTONEG_REGS_CONSTS_SVH

// ----------------------------------------------------------------
// register addresses on the management port
// ----------------------------------------------------------------
`define ADDR_LOCAL_ADV 5'h04
`define ADDR_PARTNER_ABILITY 5'h05
`define ADDR_AUTONEG_EXPANSION 5'h06

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_NEXT_PAGE 15
`define BIT_REMOTE_FAULT 13
`define BIT_100TX_FULL 8
`define BIT_100T_HALF 7
`define BIT_10T_FULL 6
`define BIT_10T_HALF 5
`define ABIL_MSB 12
`define ABIL_LSB 5
`define SEL_MSB 4
`define SEL_LSB 0
`define EXP_LP_AN_ABLE 0
`define EXP_PAGE_RX 1
`define EXP_LOCAL_NP_ABLE 2
`define EXP_LP_NP_ABLE 3

// ----------------------------------------------------------------
// reset and fixed values
// ----------------------------------------------------------------
`define SEL_IEEE_802_3 5'h01
`define LOCAL_NP_CAPABLE 1'h0
`define ABIL_RESET 4'hF
`define RF_RESET 1'h0
`define PARTNER_RESET 16'h0000
`define EXPANSION_RESET 16'h0000
`define READ_IDLE 16'h0000

`endif

// ---- rtl/autoneg_regs_pkg.sv ----
package autoneg_regs_pkg;
   typedef logic [15:0] mgmt_word_t;
   typedef logic [4:0] mgmt_addr_t;
endpackage

// ---- rtl/phy_autoneg_ability_regs.sv ----
`timescale 1ns/1ps
`include "autoneg_regs_consts.svh"
// Overview of operation
// - bit 8 advertises 100TX full, resets 1
// - bit 7 advertises 100T half, resets 1
// - bit 6 advertises 10T full, resets 1
// - local selector fixed read-only at 802.3
// - partner register read-only, zero reset, captured
// - partner bit 13 holds received remote fault
// - partner bits 12:5 hold partner abilities
// - partner bits 4:0 hold received selector
// - expansion register read-only, zero reset, status
// - local bit 15 read-only next page capability
module phy_autoneg_ability_regs
   import autoneg_regs_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // management register port
   input wire mgmt_addr_t mgmt_addr,
   input wire logic mgmt_wr,
   input wire mgmt_word_t mgmt_wdata,
   input wire logic mgmt_rd,
   output mgmt_word_t mgmt_rdata,
   // negotiation engine side
   input wire logic lp_page_valid,
   input wire mgmt_word_t lp_page_data,
   input wire logic lp_autoneg_able,
   output mgmt_word_t local_adv_word
);

   // ----------------------------------------------------------------
   // local advertisement
   // ----------------------------------------------------------------
   logic [3:0] abil_r;
   logic rf_r;
   logic adv_wr;
   mgmt_word_t adv_word;

   assign adv_wr = mgmt_wr && (mgmt_addr == `ADDR_LOCAL_ADV);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         abil_r <= `ABIL_RESET;
         rf_r <= `RF_RESET;
      end else if (adv_wr) begin
         abil_r <= mgmt_wdata[`ABIL_LSB+3:`ABIL_LSB];
         rf_r <= mgmt_wdata[`BIT_REMOTE_FAULT];
      end
   end

   // selector and next page are hard wired; reserved bits read zero
   always_comb begin
      adv_word = 16'h0000;
      adv_word[`BIT_NEXT_PAGE] = `LOCAL_NP_CAPABLE;
      adv_word[`BIT_REMOTE_FAULT] = rf_r;
      adv_word[`ABIL_LSB+3:`ABIL_LSB] = abil_r;
      adv_word[`SEL_MSB:`SEL_LSB] = `SEL_IEEE_802_3;
   end

   // a written advertisement reaches the engine on local_adv_word from the cycle after the write
   assign local_adv_word = adv_word;

   // ----------------------------------------------------------------
   // partner base page capture
   // ----------------------------------------------------------------
   mgmt_word_t partner_r;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         partner_r <= `PARTNER_RESET;
      end else if (lp_page_valid) begin
         partner_r <= lp_page_data;
      end
   end

   // ----------------------------------------------------------------
   // expansion status
   // ----------------------------------------------------------------
   logic page_rx_r;
   logic lp_an_able_r;
   logic lp_np_able_r;
   logic exp_rd;
   mgmt_word_t exp_word;

   assign exp_rd = mgmt_rd && (mgmt_addr == `ADDR_AUTONEG_EXPANSION);

   // page received clears on read; a page landing in that cycle wins
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         page_rx_r <= 1'h0;
      end else if (lp_page_valid) begin
         page_rx_r <= 1'h1;
      end else if (exp_rd) begin
         page_rx_r <= 1'h0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         lp_an_able_r <= 1'h0;
         lp_np_able_r <= 1'h0;
      end else begin
         lp_an_able_r <= lp_autoneg_able;
         lp_np_able_r <= partner_r[`BIT_NEXT_PAGE];
      end
   end

   always_comb begin
      exp_word = `EXPANSION_RESET;
      exp_word[`EXP_LP_AN_ABLE] = lp_an_able_r;
      exp_word[`EXP_PAGE_RX] = page_rx_r;
      // mirrors the fixed advertisement bit, so no flop is spent on it
      exp_word[`EXP_LOCAL_NP_ABLE] = `LOCAL_NP_CAPABLE;
      exp_word[`EXP_LP_NP_ABLE] = lp_np_able_r;
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   mgmt_word_t rdata_nxt;

   always_comb begin
      unique case (mgmt_addr)
         `ADDR_LOCAL_ADV: rdata_nxt = adv_word;
         `ADDR_PARTNER_ABILITY: rdata_nxt = partner_r;
         `ADDR_AUTONEG_EXPANSION: rdata_nxt = exp_word;
         default: rdata_nxt = `READ_IDLE;
      endcase
   end

   // holds the last read until the next read strobe
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         mgmt_rdata <= `READ_IDLE;
      end else if (mgmt_rd) begin
         mgmt_rdata <= rdata_nxt;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   sequence adv_write_s;
      adv_wr;
   endsequence

   sequence adv_read_s;
      mgmt_rd && mgmt_addr == `ADDR_LOCAL_ADV;
   endsequence

   sequence partner_read_s;
      mgmt_rd && mgmt_addr == `ADDR_PARTNER_ABILITY && !lp_page_valid;
   endsequence

   // a page then a quiet cycle, so the captured word is not overwritten
   sequence page_then_quiet_s;
      lp_page_valid ##1 !lp_page_valid;
   endsequence

   sequence flagged_read_s;
      exp_rd && page_rx_r;
   endsequence

   // local advertisement
   // reset values checked as reset falls: the disable hides every cycle with reset high
   chk_adv_100tx_full: assert property (adv_write_s |=> local_adv_word[8] == $past(mgmt_wdata[8]))
      else $error("100tx full bit did not follow write");
   chk_adv_100t_half: assert property (adv_write_s |=> local_adv_word[7] == $past(mgmt_wdata[7]))
      else $error("100t half bit did not follow write");
   chk_adv_10t_full: assert property (
      !adv_wr ##1 !adv_wr |-> $stable(local_adv_word[6]))
      else $error("10t full bit changed without write");
   chk_adv_10t_half: assert property ($fell(reset) |-> local_adv_word[`BIT_10T_HALF])
      else $error("10t half bit not set after reset");
   chk_adv_reset_set: assert property (
      $fell(reset) |-> local_adv_word[`BIT_100TX_FULL] && local_adv_word[`BIT_100T_HALF]
      && local_adv_word[`BIT_10T_FULL])
      else $error("ability bits not set after reset");
   chk_adv_other_wr: assert property (
      mgmt_wr && mgmt_addr != `ADDR_LOCAL_ADV |=> $stable(local_adv_word))
      else $error("advertisement changed by write elsewhere");
   chk_sel_fixed: assert property (adv_read_s |=> mgmt_rdata[`SEL_MSB:`SEL_LSB] == `SEL_IEEE_802_3)
      else $error("local selector not fixed");
   chk_next_page_ro: assert property (adv_read_s |=> mgmt_rdata[`BIT_NEXT_PAGE] == `LOCAL_NP_CAPABLE)
      else $error("next page bit not read-only");

   // partner capture
   chk_partner_reset: assert property ($fell(reset) |-> partner_r == `PARTNER_RESET)
      else $error("partner register not cleared by reset");
   chk_partner_ro: assert property (
      mgmt_wr && mgmt_addr == `ADDR_PARTNER_ABILITY && !lp_page_valid |=> $stable(partner_r))
      else $error("partner register changed by write");
   chk_partner_hold: assert property (!lp_page_valid |=> $stable(partner_r))
      else $error("partner register changed without page");
   chk_partner_fault: assert property (lp_page_valid |=> partner_r[13] == $past(lp_page_data[13]))
      else $error("remote fault not captured");
   chk_partner_abil: assert property (lp_page_valid |=> partner_r[12:5] == $past(lp_page_data[12:5]))
      else $error("partner abilities not captured");
   chk_partner_sel: assert property (
      page_then_quiet_s ##1 partner_read_s
      |=> mgmt_rdata[`SEL_MSB:`SEL_LSB] == $past(lp_page_data[`SEL_MSB:`SEL_LSB], 3))
      else $error("partner selector not reported");

   // expansion and read path
   chk_exp_reset: assert property ($fell(reset) |-> exp_word == `EXPANSION_RESET)
      else $error("expansion not cleared by reset");
   chk_page_set: assert property (lp_page_valid |=> page_rx_r)
      else $error("page received flag not set");
   chk_page_clear: assert property (exp_rd && !lp_page_valid |=> !page_rx_r)
      else $error("page received flag not cleared by read");
   chk_exp_page_rx: assert property (flagged_read_s |=> mgmt_rdata[`EXP_PAGE_RX])
      else $error("page received not reported");
   chk_lp_an_track: assert property (1'h1 |=> exp_word[`EXP_LP_AN_ABLE] == $past(lp_autoneg_able))
      else $error("partner negotiation ability not reported");
   chk_lp_np_track: assert property (
      lp_page_valid |-> ##2 exp_word[`EXP_LP_NP_ABLE] == $past(lp_page_data[`BIT_NEXT_PAGE], 2))
      else $error("partner next page ability not reported");
   chk_rdata_hold: assert property (!mgmt_rd |=> $stable(mgmt_rdata))
      else $error("read data changed without read");

endmodule

// ---- bench/link_partner_model.sv ----
`timescale 1ns/1ps
module link_partner_model
   import autoneg_regs_pkg::*;
(
   // bench control
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic send,
   input wire mgmt_word_t page,
   input wire logic able,
   // received base page
   output logic lp_page_valid,
   output mgmt_word_t lp_page_data,
   output logic lp_autoneg_able
);
   // data off the strobe is inverted so a stale word never passes for a page
   always_ff @(posedge ref_clk) begin
      lp_page_valid <= send && !reset;
      lp_page_data <= reset ? 16'h0000 : (send ? page : ~lp_page_data);
      lp_autoneg_able <= able;
   end
endmodule

// ---- bench/test_phy_autoneg_ability_regs.sv ----
`timescale 1ns/1ps
`include "autoneg_regs_consts.svh"
module test_phy_autoneg_ability_regs
   import autoneg_regs_pkg::*;
;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   mgmt_addr_t mgmt_addr = 5'h00;
   logic mgmt_wr = 1'b0;
   logic mgmt_rd = 1'b0;
   mgmt_word_t mgmt_wdata = 16'h0000;
   logic send = 1'b0;
   logic able = 1'b0;
   mgmt_word_t page = 16'h0000;
   logic lp_page_valid, lp_autoneg_able;
   mgmt_word_t mgmt_rdata, lp_page_data, local_adv_word, pg;
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;

   initial begin
      forever #5 ref_clk = ~ref_clk;
   end

   phy_autoneg_ability_regs u_phy_autoneg_ability_regs (.ref_clk(ref_clk), .reset(reset), .mgmt_addr(mgmt_addr),
      .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata), .mgmt_rd(mgmt_rd), .mgmt_rdata(mgmt_rdata),
      .lp_page_valid(lp_page_valid), .lp_page_data(lp_page_data), .lp_autoneg_able(lp_autoneg_able),
      .local_adv_word(local_adv_word));
   link_partner_model u_link_partner_model (.ref_clk(ref_clk), .reset(reset), .send(send), .page(page),
      .able(able), .lp_page_valid(lp_page_valid), .lp_page_data(lp_page_data), .lp_autoneg_able(lp_autoneg_able));

   // ----------------------------------------
   // access tasks
   // ----------------------------------------
   task automatic check(input string what, input mgmt_word_t exp, input mgmt_word_t got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input mgmt_addr_t a, input mgmt_word_t d);
      @(posedge ref_clk);
      mgmt_wr <= 1'b1;
      mgmt_addr <= a;
      mgmt_wdata <= d;
      @(posedge ref_clk);
      mgmt_wr <= 1'b0;
   endtask

   task automatic rd(input mgmt_addr_t a, input mgmt_word_t exp, input string what);
      @(posedge ref_clk);
      mgmt_rd <= 1'b1;
      mgmt_addr <= a;
      @(posedge ref_clk);
      mgmt_rd <= 1'b0;
      #1 check(what, exp, mgmt_rdata);
   endtask

   // extra edge lets the next-page flag land before any read
   task automatic tx_page(input mgmt_word_t p, input logic a);
      @(posedge ref_clk);
      send <= 1'b1;
      page <= p;
      able <= a;
      @(posedge ref_clk);
      send <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         bad_count++;
         give_verdict();
      end
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge ref_clk);
      reset <= 1'b0;
      rd(`ADDR_LOCAL_ADV, 16'h01E1, "local reset");
      rd(`ADDR_PARTNER_ABILITY, 16'h0000, "partner reset");
      rd(`ADDR_AUTONEG_EXPANSION, 16'h0000, "expansion reset");
      wr(`ADDR_LOCAL_ADV, 16'hFFFF);
      rd(`ADDR_LOCAL_ADV, 16'h21E1, "local ro bits");
      for (int b = 5; b < 9; b++) begin
         wr(`ADDR_LOCAL_ADV, 16'h0001 << b);
         rd(`ADDR_LOCAL_ADV, (16'h0001 << b) | 16'h0001, "ability bit");
         check("adv word", (16'h0001 << b) | 16'h0001, local_adv_word);
      end
      wr(`ADDR_PARTNER_ABILITY, 16'hFFFF);
      rd(`ADDR_PARTNER_ABILITY, 16'h0000, "partner write");
      wr(`ADDR_AUTONEG_EXPANSION, 16'hFFFF);
      rd(`ADDR_AUTONEG_EXPANSION, 16'h0000, "expansion write");
      for (int i = 0; i < 5; i++) begin
         pg = {i[0], 1'b0, ~i[0], 8'h5A + 8'(i), 5'(i)};
         tx_page(pg, i[1]);
         rd(`ADDR_PARTNER_ABILITY, pg, "partner page");
         rd(`ADDR_AUTONEG_EXPANSION, {12'h000, pg[15], 2'b01, i[1]}, "expansion");
         rd(`ADDR_AUTONEG_EXPANSION, {12'h000, pg[15], 2'b00, i[1]}, "expansion clear");
      end
      give_verdict();
   end
endmodule
